// *** bar_decode_pkg.sv ***
// Offsets, field layouts and reset values for the base address block
package bar_decode_pkg;
  // Configuration dword offsets (byte addresses)
  localparam logic [7:0] OFS_REG_WIN_BASE = 8'h10;
  localparam logic [7:0] OFS_MEM_WIN_BASE = 8'h14;
  localparam logic [7:0] OFS_UNUSED_TWO = 8'h18;
  localparam logic [7:0] OFS_UNUSED_THREE = 8'h1C;
  localparam logic [7:0] OFS_UNUSED_FOUR = 8'h20;
  localparam logic [7:0] OFS_UNUSED_FIVE = 8'h24;
  localparam logic [7:0] OFS_CARD_INFO = 8'h28;
  // Writable field positions
  localparam int REG_WIN_LSB = 12;
  localparam int MEM_WIN_LSB = 16;
  localparam int ADDR_MSB = 31;
  // Reset values
  localparam logic [19:0] REG_WIN_RST = 20'h00000;
  localparam logic [15:0] MEM_WIN_RST = 16'h0000;
  // Hardwired low bits: not prefetchable, 32-bit anywhere, memory space
  localparam logic [3:0] BAR_TYPE_BITS = 4'h0;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage

// *** bar_match_if.sv ***
// Window base values and match results passed between decoder parts
`timescale 1ns/100ps
interface bar_match_if;
  logic [19:0] reg_base;
  logic [15:0] mem_base;
  logic [31:0] addr;
  logic reg_hit;
  logic mem_hit;
  modport owner (output reg_base, output mem_base, output addr, input reg_hit, input mem_hit);
  modport matcher (input reg_base, input mem_base, input addr, output reg_hit, output mem_hit);
endinterface

// *** bar_window_match.sv ***
// Address comparators for the two memory windows
`timescale 1ns/100ps
module bar_window_match (
  bar_match_if.matcher m
);
  always_comb begin
    m.reg_hit = (m.addr[bar_decode_pkg::ADDR_MSB:bar_decode_pkg::REG_WIN_LSB] == m.reg_base); // [R1]
    m.mem_hit = (m.addr[bar_decode_pkg::ADDR_MSB:bar_decode_pkg::MEM_WIN_LSB] == m.mem_base); // [R3]
  end
endmodule

// *** pci_base_address_decode.sv ***
// Base address registers, card information pointer and window decode
// How it works
// [R1] Register window base bits 31-12 writable, matched
// [R2] Register window bits 11-4 read zero
// [R3] Memory window base bits 31-16 writable, matched
// [R4] Memory window bits 15-4 read zero
// [R5] Both bases read bit 3 zero
// [R6] Both bases read bits 2-1 as 00
// [R7] Both bases read bit 0 zero
// [R8] Unused base slots read zero, claim nothing
// [R9] Card information pointer reads zero
// [R10] Host sizes windows before programming bases
`timescale 1ns/100ps
module pci_base_address_decode (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Configuration access
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [3:0] cfg_be_i,
  output logic [31:0] cfg_rdata_o,
  // Memory cycle address decode
  input wire logic [31:0] mem_addr_i,
  input wire logic mem_space_en_i,
  output logic reg_win_hit_o,
  output logic mem_win_hit_o
);
  // Stored base fields and their next values
  logic [19:0] reg_base_ff;
  logic [19:0] nxt_reg_base;
  logic [15:0] mem_base_ff;
  logic [15:0] nxt_mem_base;

  // Registered read answer
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Offset decode results
  logic sel_reg_win;
  logic sel_mem_win;
  logic sel_unused_two;
  logic sel_unused_three;
  logic sel_unused_four;
  logic sel_unused_five;
  logic sel_unused_slot;
  logic sel_card_info;

  // Write strobe per byte lane
  logic [3:0] lane_wr;

  // Read words of the two programmable bases
  logic [31:0] reg_win_word;
  logic [31:0] mem_win_word;

  // Comparator results before the enable gate
  logic reg_match;
  logic mem_match;

  bar_match_if mi ();

  // Comparators read the stored bases, so a new base decodes after its write edge
  assign mi.reg_base = reg_base_ff;
  assign mi.mem_base = mem_base_ff;
  assign mi.addr = mem_addr_i;
  assign reg_match = mi.reg_hit;
  assign mem_match = mi.mem_hit;

  bar_window_match u_match (
    .m(mi)
  );

  // Offset decode; offsets outside the seven dwords select nothing and read zero
  always_comb begin
    sel_reg_win = 1'b0;
    sel_mem_win = 1'b0;
    sel_unused_two = 1'b0;
    sel_unused_three = 1'b0;
    sel_unused_four = 1'b0;
    sel_unused_five = 1'b0;
    sel_card_info = 1'b0;
    if (cfg_addr_i == bar_decode_pkg::OFS_REG_WIN_BASE) begin
      sel_reg_win = 1'b1; // [R1]
    end else if (cfg_addr_i == bar_decode_pkg::OFS_MEM_WIN_BASE) begin
      sel_mem_win = 1'b1; // [R3]
    end else if (cfg_addr_i == bar_decode_pkg::OFS_UNUSED_TWO) begin
      sel_unused_two = 1'b1; // [R8]
    end else if (cfg_addr_i == bar_decode_pkg::OFS_UNUSED_THREE) begin
      sel_unused_three = 1'b1; // [R8]
    end else if (cfg_addr_i == bar_decode_pkg::OFS_UNUSED_FOUR) begin
      sel_unused_four = 1'b1; // [R8]
    end else if (cfg_addr_i == bar_decode_pkg::OFS_UNUSED_FIVE) begin
      sel_unused_five = 1'b1; // [R8]
    end else if (cfg_addr_i == bar_decode_pkg::OFS_CARD_INFO) begin
      sel_card_info = 1'b1; // [R9]
    end
  end

  assign sel_unused_slot = sel_unused_two | sel_unused_three | sel_unused_four | sel_unused_five;

  // Each byte enable gates the write strobe of its own lane
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign lane_wr[lane] = cfg_wr_i & cfg_be_i[lane];
  end

  // Bits 11-0 of the dword have no storage, so writes cannot reach them
  always_comb begin
    nxt_reg_base = reg_base_ff;
    if (sel_reg_win) begin
      if (lane_wr[1]) begin
        nxt_reg_base[3:0] = cfg_wdata_i[15:12]; // [R1]
      end
      if (lane_wr[2]) begin
        nxt_reg_base[11:4] = cfg_wdata_i[23:16]; // [R1]
      end
      if (lane_wr[3]) begin
        nxt_reg_base[19:12] = cfg_wdata_i[31:24]; // [R1]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_base_ff <= bar_decode_pkg::REG_WIN_RST; // [R1]
    end else begin
      reg_base_ff <= nxt_reg_base;
    end
  end

  // Lanes 0 and 1 hold only fixed bits here, so they are not stored
  always_comb begin
    nxt_mem_base = mem_base_ff;
    if (sel_mem_win) begin
      if (lane_wr[2]) begin
        nxt_mem_base[7:0] = cfg_wdata_i[23:16]; // [R3]
      end
      if (lane_wr[3]) begin
        nxt_mem_base[15:8] = cfg_wdata_i[31:24]; // [R3]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_base_ff <= bar_decode_pkg::MEM_WIN_RST; // [R3]
    end else begin
      mem_base_ff <= nxt_mem_base;
    end
  end

  // Read-only low bits come from constants, which is what sizing relies on
  assign reg_win_word = {
    reg_base_ff, // [R1]
    8'h00, // [R2]
    bar_decode_pkg::BAR_TYPE_BITS[3], // [R5]
    bar_decode_pkg::BAR_TYPE_BITS[2:1], // [R6]
    bar_decode_pkg::BAR_TYPE_BITS[0] // [R7]
  };
  assign mem_win_word = {
    mem_base_ff, // [R3]
    12'h000, // [R4]
    bar_decode_pkg::BAR_TYPE_BITS[3], // [R5]
    bar_decode_pkg::BAR_TYPE_BITS[2:1], // [R6]
    bar_decode_pkg::BAR_TYPE_BITS[0] // [R7]
  };

  // Writes to unused slots are dropped silently
  always_comb begin
    nxt_rdata = bar_decode_pkg::ZERO_WORD;
    if (sel_reg_win) begin
      nxt_rdata = reg_win_word;
    end else if (sel_mem_win) begin
      nxt_rdata = mem_win_word;
    end else if (sel_unused_slot) begin
      nxt_rdata = bar_decode_pkg::ZERO_WORD; // [R8]
    end else if (sel_card_info) begin
      nxt_rdata = bar_decode_pkg::ZERO_WORD; // [R9]
    end
  end

  // Answer is registered, so it trails the offset by one cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= bar_decode_pkg::ZERO_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata_o = rdata_ff;

  // Only the two windows ever claim; unused slots decode nothing
  always_comb begin
    reg_win_hit_o = 1'b0;
    mem_win_hit_o = 1'b0;
    if (mem_space_en_i) begin
      reg_win_hit_o = reg_match; // [R1] [R8]
      mem_win_hit_o = mem_match; // [R3] [R8]
    end
  end
endmodule

// *** pci_base_address_decode_asserts.sv ***
// Checker for base register readback and window decode
`timescale 1ns/100ps
module bar_decode_chk (
  input wire logic core_clk_i, nrst_i, cfg_wr_i, mem_space_en_i, reg_win_hit_o, mem_win_hit_o,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i, cfg_rdata_o, mem_addr_i);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence wr_rd(a); cfg_wr_i && cfg_addr_i == a && cfg_be_i == 4'hF ##1 cfg_addr_i == a; endsequence
  low_bits_a: assert property (cfg_rdata_o[3:0] == 4'h0) else $error("type bits");
  reg_size_a: assert property ($past(cfg_addr_i) == 8'h10 |-> !cfg_rdata_o[11:4])
    else $error("reg size");
  mem_size_a: assert property ($past(cfg_addr_i) == 8'h14 |-> !cfg_rdata_o[15:4])
    else $error("mem size");
  unused_zero_a: assert property ($past(cfg_addr_i) inside {8'h18, 8'h1C, 8'h20, 8'h24}
    |-> !cfg_rdata_o) else $error("unused slot");
  card_zero_a: assert property ($past(cfg_addr_i) == 8'h28 |-> !cfg_rdata_o)
    else $error("card pointer");
  reg_base_a: assert property (wr_rd(8'h10) |=>
    cfg_rdata_o >> 12 == $past(cfg_wdata_i, 2) >> 12) else $error("reg base");
  mem_base_a: assert property (wr_rd(8'h14) |=>
    cfg_rdata_o >> 16 == $past(cfg_wdata_i, 2) >> 16) else $error("mem base");
  hit_gate_a: assert property (!mem_space_en_i |-> !reg_win_hit_o && !mem_win_hit_o)
    else $error("hit while off");
  cover property (reg_win_hit_o);
  cover property (mem_win_hit_o);
  cover property (wr_rd(8'h14));
  cover property (cfg_wr_i && cfg_be_i != 4'hF);
endmodule

// *** pci_host_model.sv ***
// Host model issuing configuration and memory cycles
`timescale 1ns/100ps
module pci_host_model (
  input wire logic clk_i,
  output logic wr_o, en_o,
  output logic [7:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o, maddr_o);
  initial {wr_o, en_o, addr_o, be_o, wdata_o, maddr_o} = '0;
  // Data bus inverted once released so a stale value never looks valid
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge clk_i) {wr_o, addr_o, wdata_o, be_o} = {1'b1, a, d, b};
    @(negedge clk_i) {wr_o, wdata_o} = {1'b0, ~d};
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wb(a, d, 4'hF);
  endtask
  // Reads need only the offset; the answer follows one edge later
  task automatic rd(input logic [7:0] a);
    @(negedge clk_i) addr_o = a;
  endtask
  task automatic m(input logic [31:0] a, input logic e);
    @(negedge clk_i) {maddr_o, en_o} = {a, e};
  endtask
endmodule

// *** test_pci_base_address_decode.sv ***
// Top testbench for the base address block
`timescale 1ns/100ps
module test_pci_base_address_decode;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, cfg_wr_i, mem_space_en_i, reg_win_hit_o, mem_win_hit_o;
  logic [7:0] cfg_addr_i;
  logic [3:0] cfg_be_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, mem_addr_i;
  int fail_count = 0, checks = 0, cyc = 0;
  always #25 core_clk_i = ~core_clk_i;
  pci_base_address_decode i_dut (.*);
  pci_host_model i_host (.clk_i(core_clk_i), .wr_o(cfg_wr_i), .en_o(mem_space_en_i),
    .addr_o(cfg_addr_i), .be_o(cfg_be_i), .wdata_o(cfg_wdata_i), .maddr_o(mem_addr_i));
  task automatic chk(input logic [31:0] s, e, input string n);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Read answer is registered, so it is taken one cycle after the address
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    i_host.rd(a);
    @(negedge core_clk_i);
    chk(cfg_rdata_o, e, "cfg read");
  endtask
  task automatic t_size;
    for (int a = 8'h10; a <= 8'h28; a += 4) r(8'(a), 32'h00000000);
    for (int a = 8'h10; a <= 8'h28; a += 4) i_host.w(8'(a), 32'hFFFFFFFF);
    r(8'h10, 32'hFFFFF000);
    r(8'h14, 32'hFFFF0000);
    for (int a = 8'h18; a <= 8'h28; a += 4) r(8'(a), 32'h00000000);
  endtask
  task automatic hit(input logic [31:0] a, input logic e, input logic [1:0] x);
    i_host.m(a, e);
    #5 chk({reg_win_hit_o, mem_win_hit_o}, x, "hits");
  endtask
  task automatic t_hit;
    i_host.w(8'h10, 32'h12345ABC);
    i_host.w(8'h14, 32'hABCD1234);
    r(8'h10, 32'h12345000);
    hit(32'h12345FFF, 1'b1, 2'h2);
    hit(32'h12346000, 1'b1, 2'h0);
    hit(32'hABCDFFFF, 1'b1, 2'h1);
    hit(32'hABCC0000, 1'b1, 2'h0);
    hit(32'h12345000, 1'b0, 2'h0);
    // Partial byte enables: only the enabled bytes of the writable field move
    i_host.wb(8'h10, 32'h00AA0000, 4'h4);
    r(8'h10, 32'h12AA5000);
    hit(32'h12AA5123, 1'b1, 2'h2);
    i_host.wb(8'h14, 32'h55FFFFFF, 4'h8);
    r(8'h14, 32'h55CD0000);
    i_host.wb(8'h14, 32'hFFFFFFFF, 4'h3);
    r(8'h14, 32'h55CD0000);
    hit(32'h55CD8000, 1'b1, 2'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk_i) if (++cyc > 2000) begin
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_size();
    t_hit();
    print_verdict();
  end
endmodule
bind pci_base_address_decode bar_decode_chk u_chk (.*);
